// ===== hdl/pll_mode_sequencer.v
// Purpose: mode and reset sequencer of a jitter-attenuating pll
// Assumes: synchronous inputs, axi4-lite master keeps protocol
// Notes: registers: ctrl 0x0, bw 0x4, status 0x8, plan 0xc
// Function
// - init loads defaults, no clocks meanwhile
// - bus usable only after init
// - hard reset reloads everything like power-up
// - hard reset from pin or bit
// - soft reset applies pending config only
// - exactly one of six modes
// - free-run right after init
// - free-run while no input valid
// - free-run uses reference oscillator only
// - valid input starts lock acquisition
// - fast bandwidth while acquiring if enabled
// - fast bandwidth 20 hz to 4 khz
// - loop bandwidth 20 hz to 4 khz
// - locked follows selected input
// - lock shown on pin and bit
// - manual or automatic input selection
// - frequency plan writable and loaded at init
// - fail with history enters holdover
// - fail without history enters frozen mode from locked, free-run from acquisition
// - history kept up to 120 seconds
// - valid input leaves holdover, reacquires
`timescale 1ns/100ps
`include "pll_seq_defines.vh"
module pll_mode_sequencer #(
   parameter N_IN = 4,
   parameter [33:0] HIST_CYCLES = `HIST_CYCLES
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // device pins
   input wire hard_reset_pin_n,
   input wire [N_IN-1:0] in_valid,
   input wire lock_detect,
   input wire [1:0] in_sel_pin,
   input wire [31:0] nvm_ctrl,
   input wire [31:0] nvm_bw,
   input wire [31:0] nvm_plan,
   // pll core control
   output reg [2:0] mode_q,
   output reg clocks_en_q,
   output reg use_reference_osc_q,
   output reg [1:0] active_in_q,
   output reg [11:0] pll_bw_q,
   output reg [31:0] plan_q,
   output reg soft_apply_q,
   output reg lock_loss_indicator,
   // axi4-lite write address
   input wire [3:0] s_awaddr,
   input wire s_awvalid,
   output wire s_awready,
   // axi4-lite write data
   input wire [31:0] s_wdata,
   input wire [3:0] s_wstrb,
   input wire s_wvalid,
   output wire s_wready,
   // axi4-lite write response
   output reg [1:0] s_bresp,
   output reg s_bvalid,
   input wire s_bready,
   // axi4-lite read
   input wire [3:0] s_araddr,
   input wire s_arvalid,
   output wire s_arready,
   output reg [31:0] s_rdata,
   output reg [1:0] s_rresp,
   output reg s_rvalid,
   input wire s_rready
);
   reg [31:0] ctrl_q; // control register
   reg [31:0] bw_q; // loop and fast bandwidth codes
   reg [7:0] init_cnt_q; // download counter
   reg init_done_q; // initialization finished
   reg [33:0] hist_cnt_q; // history age in cycles
   reg hist_valid_q; // history usable for holdover
   reg [1:0] lock_in_q; // input acquired on
   reg [3:0] aw_a_q; // latched write address
   reg aw_have_q; // write address held
   reg [31:0] w_d_q; // latched write data
   reg [3:0] w_s_q; // latched strobes
   reg w_have_q; // write data held
   reg [2:0] mode_d; // next mode
   wire hard_rst; // combined hard reset
   wire [1:0] sel; // picked input
   wire sel_ok; // picked input valid
   wire any_valid; // some input valid
   wire do_write; // write both halves present
   wire [11:0] bw_loop; // clamped loop code
   wire [11:0] bw_fast; // clamped fast code
   reg [31:0] wr_merge; // strobe merged word
   reg [31:0] old_word; // current register value
   integer b;
   assign hard_rst = !aresetn || !hard_reset_pin_n || ctrl_q[`CTRL_HARD_RST];
   assign any_valid = |in_valid;
   input_picker #(
      .N(N_IN),
      .W(2)
   ) u_pick (
      .aclk(aclk),
      .aresetn(!hard_rst),
      .auto_sel(ctrl_q[`CTRL_AUTO_SEL]),
      .manual_sel(ctrl_q[`CTRL_AUTO_SEL] ? in_sel_pin :
                  ctrl_q[`CTRL_SEL_HI:`CTRL_SEL_LO]),
      .in_valid(in_valid),
      .sel_q(sel),
      .sel_ok_q(sel_ok)
   );
   assign bw_fast = (bw_q[27:16] < `BW_MIN) ? `BW_MIN :
                    (bw_q[27:16] > `BW_MAX) ? `BW_MAX : bw_q[27:16];
   assign bw_loop = (bw_q[11:0] < `BW_MIN) ? `BW_MIN :
                    (bw_q[11:0] > `BW_MAX) ? `BW_MAX : bw_q[11:0];
   // bus stalls until the core has left init
   // gating on mode keeps the bus shut in the one cycle where init_done is set
   // but the mode register still shows init
   assign s_awready = (mode_q != `MODE_INIT) && !aw_have_q && !s_bvalid;
   assign s_wready = (mode_q != `MODE_INIT) && !w_have_q && !s_bvalid;
   assign s_arready = (mode_q != `MODE_INIT) && !s_rvalid;
   assign do_write = aw_have_q && w_have_q;
   // selected register for strobe merge
   always @* begin
      case (aw_a_q)
         `REG_CTRL: old_word = ctrl_q;
         `REG_BW: old_word = bw_q;
         `REG_PLAN: old_word = plan_q;
         default: old_word = 32'h0000_0000;
      endcase
      wr_merge = old_word;
      for (b = 0; b < 4; b = b + 1) begin
         if (w_s_q[b]) begin
            wr_merge[b*8 +: 8] = w_d_q[b*8 +: 8];
         end
      end
   end
   // init download counter and done flag cleared by hard reset
   always @(posedge aclk) begin
      if (hard_rst) begin
         init_cnt_q <= 8'h00;
         init_done_q <= 1'b0;
      end else if (!init_done_q) begin
         init_cnt_q <= init_cnt_q + 8'h01;
         if (init_cnt_q == `INIT_CYCLES - 8'h01) begin
            init_done_q <= 1'b1;
         end
      end
   end
   // register file and write channel
   always @(posedge aclk) begin
      if (hard_rst) begin
         ctrl_q <= `CTRL_RST;
         bw_q <= `BW_RST;
         plan_q <= `PLAN_RST;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_a_q <= 4'h0;
         w_d_q <= 32'h0000_0000;
         w_s_q <= 4'h0;
         s_bvalid <= 1'b0;
         s_bresp <= 2'b00;
         soft_apply_q <= 1'b0;
      end else if (!init_done_q) begin
         // defaults and plan loaded from nvm
         if (init_cnt_q == `INIT_CYCLES - 8'h01) begin
            ctrl_q <= nvm_ctrl & ~32'h0000_0003;
            bw_q <= nvm_bw;
            plan_q <= nvm_plan;
         end
      end else begin
         soft_apply_q <= 1'b0;
         // soft reset is a one-shot apply
         if (ctrl_q[`CTRL_SOFT_RST]) begin
            ctrl_q[`CTRL_SOFT_RST] <= 1'b0;
            soft_apply_q <= 1'b1;
         end
         if (s_awvalid && s_awready) begin
            aw_a_q <= s_awaddr;
            aw_have_q <= 1'b1;
         end
         if (s_wvalid && s_wready) begin
            w_d_q <= s_wdata;
            w_s_q <= s_wstrb;
            w_have_q <= 1'b1;
         end
         if (do_write) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp <= 2'b00;
            case (aw_a_q)
               `REG_CTRL: ctrl_q <= wr_merge;
               `REG_BW: bw_q <= wr_merge;
               `REG_PLAN: plan_q <= wr_merge;
               `REG_STATUS: s_bresp <= 2'b10;
               default: s_bresp <= 2'b10;
            endcase
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
         end
      end
   end
   // read channel
   always @(posedge aclk) begin
      if (hard_rst) begin
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0000_0000;
         s_rresp <= 2'b00;
      end else if (s_arvalid && s_arready) begin
         s_rvalid <= 1'b1;
         s_rresp <= 2'b00;
         case (s_araddr)
            `REG_CTRL: s_rdata <= ctrl_q;
            `REG_BW: s_rdata <= bw_q;
            `REG_STATUS: s_rdata <= {24'h000000, hist_valid_q, sel_ok,
                                    lock_loss_indicator, active_in_q, mode_q};
            `REG_PLAN: s_rdata <= plan_q;
            default: begin
               s_rdata <= 32'h0000_0000;
               s_rresp <= 2'b10;
            end
         endcase
      end else if (s_rvalid && s_rready) begin
         s_rvalid <= 1'b0;
      end
   end
   // mode transitions, one mode at a time
   always @* begin
      mode_d = mode_q;
      case (mode_q)
         `MODE_INIT: begin
            if (init_done_q) begin
               mode_d = `MODE_FREERUN;
            end
         end
         `MODE_FREERUN: begin
            if (any_valid && sel_ok) begin
               mode_d = `MODE_ACQ;
            end
         end
         `MODE_ACQ: begin
            if (!sel_ok) begin
               mode_d = hist_valid_q ? `MODE_HOLD : `MODE_FREERUN;
            end else if (sel != lock_in_q) begin
               mode_d = `MODE_ACQ;
            end else if (lock_detect) begin
               mode_d = `MODE_LOCKED;
            end
         end
         `MODE_LOCKED: begin
            if (!sel_ok) begin
               mode_d = hist_valid_q ? `MODE_HOLD : `MODE_FROZEN;
            end else if (sel != lock_in_q || !lock_detect) begin
               mode_d = `MODE_ACQ;
            end
         end
         `MODE_HOLD, `MODE_FROZEN: begin
            if (sel_ok) begin
               mode_d = `MODE_ACQ;
            end
         end
         default: mode_d = `MODE_INIT;
      endcase
   end
   // mode register and core steering
   always @(posedge aclk) begin
      if (hard_rst) begin
         mode_q <= `MODE_INIT;
         lock_in_q <= 2'b00;
         clocks_en_q <= 1'b0;
         use_reference_osc_q <= 1'b1;
         active_in_q <= 2'b00;
         pll_bw_q <= `BW_MAX;
         lock_loss_indicator <= 1'b1;
      end else begin
         mode_q <= mode_d;
         if (mode_d == `MODE_ACQ) begin
            lock_in_q <= sel;
         end
         clocks_en_q <= (mode_d != `MODE_INIT);
         use_reference_osc_q <= (mode_d == `MODE_FREERUN) || (mode_d == `MODE_INIT);
         active_in_q <= sel;
         if (mode_d == `MODE_ACQ && ctrl_q[`CTRL_FAST_EN]) begin
            pll_bw_q <= bw_fast;
         end else begin
            pll_bw_q <= bw_loop;
         end
         lock_loss_indicator <= (mode_d != `MODE_LOCKED);
      end
   end
   always @(posedge aclk) begin
      if (hard_rst) begin
         hist_cnt_q <= 34'd0;
         hist_valid_q <= 1'b0;
      end else if (mode_q == `MODE_LOCKED) begin
         hist_valid_q <= 1'b1;
         if (hist_cnt_q < HIST_CYCLES) begin
            hist_cnt_q <= hist_cnt_q + 34'd1;
         end
      end else if (mode_q == `MODE_FREERUN) begin
         hist_cnt_q <= 34'd0;
         hist_valid_q <= 1'b0;
      end
   end
endmodule

// ===== hdl/pll_seq_defines.vh
// Purpose: constants for the pll mode sequencer
// Assumes: 100 MHz aclk, axi4-lite 32-bit register words
// Notes: offsets are byte addresses
`ifndef PLL_SEQ_DEFINES_VH
`define PLL_SEQ_DEFINES_VH
// register byte offsets
`define REG_CTRL 4'h0
`define REG_BW 4'h4
`define REG_STATUS 4'h8
`define REG_PLAN 4'hc
// control field positions
`define CTRL_HARD_RST 0
`define CTRL_SOFT_RST 1
`define CTRL_FAST_EN 2
`define CTRL_AUTO_SEL 3
`define CTRL_SEL_LO 4
`define CTRL_SEL_HI 5
// bandwidth code limits (hz / 10), 20 hz .. 4 khz
`define BW_MIN 12'h002
`define BW_MAX 12'h190
// reset values
`define CTRL_RST 32'h0000_0004
`define BW_RST 32'h0190_0010
`define PLAN_RST 32'h0000_0000
// init download length in cycles
`define INIT_CYCLES 8'h20
// modes of the pll core
`define MODE_INIT 3'h0
`define MODE_FREERUN 3'h1
`define MODE_FROZEN 3'h2
`define MODE_ACQ 3'h3
`define MODE_LOCKED 3'h4
`define MODE_HOLD 3'h5
// holdover history time: 120 s at 100 MHz
`define HIST_SECONDS 120
`define HIST_CYCLES 34'd12000000000
`endif

// ===== hdl/input_picker.v
// Purpose: chooses one clock input, manual or by priority
// Assumes: valid bits are qualified and synchronous
// Notes: lowest index has highest priority in automatic mode
`timescale 1ns/100ps
module input_picker #(
   parameter N = 4,
   parameter W = 2
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // selection control
   input wire auto_sel,
   input wire [W-1:0] manual_sel,
   input wire [N-1:0] in_valid,
   // result
   output reg [W-1:0] sel_q,
   output reg sel_ok_q
);
   reg [W-1:0] pick_d; // candidate index
   reg found_d; // a valid candidate exists
   integer i;
   // priority search or manual choice
   always @* begin
      pick_d = manual_sel;
      found_d = 1'b0;
      if (auto_sel) begin
         for (i = N - 1; i >= 0; i = i - 1) begin
            if (in_valid[i]) begin
               pick_d = i[W-1:0];
               found_d = 1'b1;
            end
         end
      end else begin
         found_d = in_valid[manual_sel];
      end
   end
   // registered selection
   always @(posedge aclk) begin
      if (!aresetn) begin
         sel_q <= {W{1'b0}};
         sel_ok_q <= 1'b0;
      end else begin
         sel_q <= pick_d;
         sel_ok_q <= found_d;
      end
   end
endmodule

// ===== bench/pll_seq_asserts.sv
// Purpose: port-level checks of the pll mode sequencer
// Assumes: one aclk domain, sync active-low aresetn
// Notes: bound to every sequencer instance
`timescale 1ns/100ps
`include "pll_seq_defines.vh"
module pll_seq_asserts #(
   parameter N_IN = 4
) (
   // clock, reset and pins
   input wire aclk,
   input wire aresetn,
   input wire hard_reset_pin_n,
   input wire [N_IN-1:0] in_valid,
   input wire lock_detect,
   // core control
   input wire [2:0] mode_q,
   input wire clocks_en_q,
   input wire use_reference_osc_q,
   input wire [11:0] pll_bw_q,
   input wire soft_apply_q,
   input wire lock_loss_indicator,
   // bus readiness
   input wire s_awready,
   input wire s_arready
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   init_no_clk_a: assert property (mode_q == `MODE_INIT |-> !clocks_en_q)
      else $error("clocks enabled during init");
   init_bus_a: assert property (mode_q == `MODE_INIT |-> !s_awready && !s_arready)
      else $error("bus ready during init");
   mode_range_a: assert property (mode_q <= `MODE_HOLD)
      else $error("mode out of range");
   freerun_first_a: assert property ($past(mode_q) == `MODE_INIT && mode_q != `MODE_INIT
      |-> mode_q == `MODE_FREERUN) else $error("init not left to free-run");
   freerun_stay_a: assert property (mode_q == `MODE_FREERUN && in_valid == 0
      |=> mode_q inside {`MODE_INIT, `MODE_FREERUN}) else $error("left free-run");
   acq_start_a: assert property (mode_q == `MODE_FREERUN && &in_valid
      |-> ##[1:4] mode_q != `MODE_FREERUN) else $error("no acquisition");
   osc_free_a: assert property (mode_q inside {`MODE_INIT, `MODE_FREERUN}
      |-> use_reference_osc_q) else $error("free-run off reference");
   osc_lock_a: assert property (mode_q == `MODE_LOCKED |-> !use_reference_osc_q)
      else $error("locked on reference");
   lol_pin_a: assert property ($stable(mode_q)
      |-> lock_loss_indicator == (mode_q != `MODE_LOCKED)) else $error("lock pin wrong");
   lock_cause_a: assert property (mode_q == `MODE_LOCKED && $past(mode_q) != `MODE_LOCKED
      |-> $past(lock_detect)) else $error("locked without detector");
   pin_reset_a: assert property (!hard_reset_pin_n
      |=> mode_q == `MODE_INIT && !clocks_en_q) else $error("pin reset ignored");
   bw_range_a: assert property (pll_bw_q >= `BW_MIN && pll_bw_q <= `BW_MAX)
      else $error("bandwidth out of range");
   soft_keep_a: assert property (soft_apply_q && hard_reset_pin_n
      |=> mode_q != `MODE_INIT) else $error("soft reset reinitialised");
   // main scenarios reached
   cover property (mode_q == `MODE_LOCKED);
   cover property (mode_q == `MODE_HOLD);
   cover property (soft_apply_q);
endmodule
bind pll_mode_sequencer pll_seq_asserts #(.N_IN(N_IN)) pll_seq_asserts_inst (.*);

// ===== bench/pll_far_side.sv
// Purpose: input clocks and lock detector seen by the sequencer
// Assumes: valid levels already qualified
// Notes: lock_wait sets a prompt or a slow lock
`timescale 1ns/100ps
`include "pll_seq_defines.vh"
module pll_far_side (
   // clock and control from the bench, mode from the sequencer
   input wire aclk,
   input wire [3:0] valid_set,
   input wire [7:0] lock_wait,
   input wire [2:0] mode_q,
   // towards the sequencer
   output logic [3:0] in_valid = 4'h0,
   output logic lock_detect = 1'b0
);
   logic [7:0] cnt_q = 8'h00; // cycles spent acquiring
   // lock reported only after lock_wait cycles of acquisition
   always @(posedge aclk) begin
      in_valid <= valid_set;
      if (mode_q == `MODE_ACQ && valid_set != 0) begin
         cnt_q <= cnt_q + 8'h01;
         lock_detect <= (cnt_q >= lock_wait);
      end else if (mode_q != `MODE_LOCKED || valid_set == 0) begin
         cnt_q <= 8'h00;
         lock_detect <= 1'b0;
      end
   end
endmodule

// ===== bench/pll_mode_sequencer_tb.sv
// Purpose: self-checking bench of the pll mode sequencer
// Assumes: 100 MHz aclk, axi4-lite master per channel rules
// Notes: reads are checked from a queue of expected words
`timescale 1ns/100ps
`include "pll_seq_defines.vh"
module pll_mode_sequencer_tb;
   logic aclk, aresetn, hard_reset_pin_n, lock_detect, soft_seen;
   logic [3:0] in_valid, valid_set, s_awaddr, s_araddr, s_wstrb;
   logic [1:0] in_sel_pin;
   logic [7:0] lock_wait;
   logic [31:0] nvm_ctrl, nvm_bw, nvm_plan, s_wdata, w, p;
   logic s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
   wire [2:0] mode_q;
   wire [1:0] active_in_q, s_bresp, s_rresp;
   wire [11:0] pll_bw_q;
   wire [31:0] plan_q, s_rdata;
   wire clocks_en_q, use_reference_osc_q, soft_apply_q, lock_loss_indicator;
   wire s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [63:0] exp_q[$]; // {mask, value} per read
   int n_fail, compares;
   integer seed;
   pll_mode_sequencer #(.N_IN(4), .HIST_CYCLES(34'd16)) pll_mode_sequencer_inst (.*);
   pll_far_side pll_far_side_inst (.aclk(aclk), .valid_set(valid_set), .lock_wait(lock_wait),
      .mode_q(mode_q), .in_valid(in_valid), .lock_detect(lock_detect));
   task check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task summarize;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // bounded wait for a mode, then compare
   task wait_mode(input logic [2:0] m);
      int n;
      for (n = 0; mode_q !== m && n < 200; n++) @(posedge aclk);
      check(32'(mode_q), 32'(m));
   endtask
   task wait_ready;
      int n;
      for (n = 0; s_awready !== 1'b1 && n < 200; n++) @(posedge aclk);
   endtask
   // write; a hard reset may swallow the answer
   task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      bit done;
      s_awaddr <= a; s_wdata <= d; s_wstrb <= 4'hf;
      s_awvalid <= 1; s_wvalid <= 1; s_bready <= 1;
      done = 0;
      for (n = 0; !done && n < 300; n++) begin
         @(posedge aclk);
         if (s_awready) s_awvalid <= 0;
         if (s_wready) s_wvalid <= 0;
         if (s_bvalid) begin done = 1; check(32'(s_bresp), 32'(er)); end
         else if (mode_q === `MODE_INIT) done = 1;
      end
      if (!done) begin n_fail++; $display("Error at %0t: no write answer", $time); end
      s_awvalid <= 0; s_wvalid <= 0; s_bready <= 0;
      @(posedge aclk);
   endtask
   task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
      int n;
      exp_q.push_back({m, e});
      s_araddr <= a; s_arvalid <= 1; s_rready <= 1;
      for (n = 0; !(s_rvalid === 1'b1) && n < 300; n++) begin
         @(posedge aclk);
         if (s_arready) s_arvalid <= 0;
      end
      if (s_rvalid !== 1'b1) begin
         n_fail++;
         $display("Error at %0t: no read answer", $time);
      end
      s_arvalid <= 0; s_rready <= 0;
      @(posedge aclk);
   endtask
   // read monitor takes the oldest expectation
   always @(posedge aclk) begin
      if (soft_apply_q === 1'b1) soft_seen <= 1;
      if (s_rvalid && s_rready) begin
         if (exp_q.size() == 0) begin n_fail++; $display("Error at %0t: stray read", $time); end
         else begin p = exp_q[0][63:32]; check(s_rdata & p, exp_q.pop_front() & {32'h0, p}); end
      end
   end
   initial begin aclk = 0; forever #5 aclk = ~aclk; end
   initial begin #200000; n_fail++; $display("Error at %0t: watchdog", $time); summarize; end
   initial begin
      seed = 32'hd1b3; n_fail = 0; compares = 0; soft_seen = 0;
      aresetn = 0; hard_reset_pin_n = 1; in_sel_pin = 2'h0; valid_set = 4'h0; lock_wait = 8'd40;
      nvm_ctrl = `CTRL_RST; nvm_bw = `BW_RST; nvm_plan = $random(seed);
      s_awaddr = 0; s_araddr = 0; s_wstrb = 0; s_wdata = 0;
      s_awvalid = 0; s_wvalid = 0; s_bready = 0; s_arvalid = 0; s_rready = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      check(32'(clocks_en_q), 32'h0);
      wait_ready();
      rd(`REG_STATUS, 32'h21, 32'h27);
      rd(`REG_PLAN, nvm_plan, 32'hffff_ffff);
      rd(`REG_BW, `BW_RST, 32'hffff_ffff);
      $display("test init done");
      w = $random(seed); in_sel_pin <= 2'($random(seed));
      wr(`REG_PLAN, w, 2'h0);
      rd(`REG_PLAN, w, 32'hffff_ffff);
      check(plan_q, w);
      wr(`REG_STATUS, 32'hff, 2'h2);
      wr(`REG_BW, 32'h0190_0001, 2'h0);
      repeat (3) @(posedge aclk);
      check(32'(pll_bw_q), 32'h2);
      wr(`REG_BW, 32'h0190_000a, 2'h0);
      wr(`REG_CTRL, 32'h0c, 2'h0);
      $display("test registers done");
      valid_set <= 4'b0100;
      wait_mode(`MODE_ACQ);
      check(32'(active_in_q), 32'h2);
      check(32'(pll_bw_q), 32'h190);
      rd(`REG_STATUS, 32'h33, 32'h3f);
      wait_mode(`MODE_LOCKED);
      check(32'(pll_bw_q), 32'h00a);
      check(32'(lock_loss_indicator), 32'h0);
      check(32'(use_reference_osc_q), 32'h0);
      valid_set <= 4'b0000;
      wait_mode(`MODE_HOLD);
      valid_set <= 4'b0001;
      wait_mode(`MODE_ACQ);
      check(32'(active_in_q), 32'h0);
      $display("test modes done");
      w = $random(seed);
      wr(`REG_PLAN, w, 2'h0);
      wr(`REG_CTRL, 32'h0e, 2'h0);
      repeat (2) @(posedge aclk);
      check(32'(soft_seen), 32'h1);
      rd(`REG_PLAN, w, 32'hffff_ffff);
      valid_set <= 4'b0000;
      hard_reset_pin_n <= 0;
      @(posedge aclk);
      hard_reset_pin_n <= 1;
      @(posedge aclk);
      check(32'(mode_q), 32'(`MODE_INIT));
      wait_ready();
      rd(`REG_PLAN, nvm_plan, 32'hffff_ffff);
      $display("test resets done");
      lock_wait <= 8'd0;
      wr(`REG_CTRL, 32'h34, 2'h0);
      valid_set <= 4'b1111;
      wait_mode(`MODE_ACQ);
      check(32'(active_in_q), 32'h3);
      wait_mode(`MODE_LOCKED);
      wr(`REG_CTRL, 32'h01, 2'h0);
      wait_mode(`MODE_INIT);
      wait_ready();
      rd(`REG_CTRL, `CTRL_RST, 32'hffff_ffff);
      $display("test manual done");
      summarize;
   end
endmodule
